// >>> hdl/rx_port_config_consts.vh
`ifndef RX_PORT_CONFIG_CONSTS_VH
`define RX_PORT_CONFIG_CONSTS_VH

// register offsets
`define RPC_OFS_PORT_SEL 8'h4c
`define RPC_OFS_ALIAS7 8'h6c
`define RPC_OFS_SETUP 8'h6d
`define RPC_OFS_BC_SEL_LO 8'h6e

// reset values
`define RPC_RST_PORT_SEL 8'h00
`define RPC_RST_ALIAS7 8'h00
`define RPC_RST_SETUP_HI 5'h0f
`define RPC_RST_BC_SEL_LO 8'h88

// port select field
`define RPC_PSEL_W 2

// alias register fields
`define RPC_ALIAS_MSB 7
`define RPC_ALIAS_LSB 1
`define RPC_AUTO_ACK_BIT 0

// port setup fields
`define RPC_WAIT_FS1_BIT 7
`define RPC_WAIT_FS_BIT 6
`define RPC_FWD_CKSUM_BIT 5
`define RPC_FWD_ECC_BIT 4
`define RPC_LINE_LEN_BIT 3
`define RPC_RSVD_BIT 2
`define RPC_MODE_MSB 1
`define RPC_MODE_LSB 0

// input modes
`define RPC_MODE_CSI2 2'h0
`define RPC_MODE_RAW12_LF 2'h1
`define RPC_MODE_RAW12_HF 2'h2
`define RPC_MODE_RAW10 2'h3

// back channel select codes
`define RPC_BC_PIN1_MSB 7
`define RPC_BC_PIN1_LSB 4
`define RPC_BC_PIN0_MSB 3
`define RPC_BC_PIN0_LSB 0
`define RPC_BC_CONST0 4'h8
`define RPC_BC_CONST1 4'h9
`define RPC_BC_FSYNC 4'ha

`endif

// >>> hdl/rx_port_config_regs.v
// Function
// - each port holds a 7-bit remote alias in bits 7:1 used to decode incoming I2C addresses.
// - a matching transaction is forwarded with the remote target identifier as its address.
// - an alias of zero disables decoding for that slot.
// - with auto-acknowledge set, every write to the aliased target is acknowledged locally.
// - bit 7 makes CSI-2 receive drop packets until a Frame Start with count 1, not in raw modes.
// - bit 6 (reset 1) makes CSI-2 receive drop packets until any Frame Start, not in raw modes.
// - bit 5 (reset 1) forwards checksum-errored CSI-2 packets when 1, drops them when 0.
// - bit 4 (reset 1) forwards header-ECC-errored packets when 1, drops them when 0.
// - in raw modes bit 3 set discards a truncated first video line, clear forwards it.
// - in CSI-2 mode bit 3 (reset 1) forwards length-errored packets when 1, drops them when 0.
// - the 2-bit input mode in bits 1:0 loads from the strap and is writable.
// - bits 7:4 (reset 8) select the source of back channel pin 1 of the port.
// - bits 3:0 (reset 8) select the source of back channel pin 0 of the port.
// - a select code with top bit clear forwards local pin number code[2:0].
// - code 8 sends 0, code 9 sends 1, code 10 sends frame sync, 11..15 are reserved.
// - the registers exist per port and the port select register picks the accessed copy.
`timescale 1ns/1ps
`include "rx_port_config_consts.vh"

module rx_port_config_regs #(
  parameter NUM_PORTS = 4
) (
  input wire SYS_CLK,
  input wire NRST,
  input wire [7:0] REG_ADDR,
  input wire REG_WR,
  input wire REG_RD,
  input wire [7:0] REG_WDATA,
  output reg [7:0] REG_RDATA,
  input wire [1:0] STRAP_MODE,
  input wire TXN_VALID,
  input wire TXN_WRITE,
  input wire [6:0] TXN_ADDR,
  input wire [7*NUM_PORTS-1:0] REMOTE_ID,
  output reg [NUM_PORTS-1:0] ALIAS_HIT,
  output reg [NUM_PORTS-1:0] ALIAS_ACK,
  output reg [7*NUM_PORTS-1:0] REMAP_ADDR,
  input wire [NUM_PORTS-1:0] PKT_VALID,
  input wire [NUM_PORTS-1:0] PKT_FS,
  input wire [NUM_PORTS-1:0] PKT_FCNT_ONE,
  input wire [NUM_PORTS-1:0] PKT_CKSUM_ERR,
  input wire [NUM_PORTS-1:0] PKT_ECC_ERR,
  input wire [NUM_PORTS-1:0] PKT_LEN_ERR,
  input wire [NUM_PORTS-1:0] PKT_LINE_TRUNC,
  output reg [NUM_PORTS-1:0] PKT_PASS,
  output wire [2*NUM_PORTS-1:0] INPUT_MODE,
  input wire [7:0] LOCAL_GPIO,
  input wire FRAME_SYNC,
  output reg [NUM_PORTS-1:0] BC_PIN0,
  output reg [NUM_PORTS-1:0] BC_PIN1
);

  // back channel source decode, shared by both pins of every port
  function bc_source;
    input [3:0] sel;
    input [7:0] gpio;
    input fsync;
    begin
      // local pin forward
      if (!sel[3]) begin
        bc_source = gpio[sel[2:0]];
      end else begin
        // constants and frame sync
        case (sel)
          `RPC_BC_CONST0: bc_source = 1'b0;
          `RPC_BC_CONST1: bc_source = 1'b1;
          `RPC_BC_FSYNC: bc_source = fsync;
          // reserved codes send a quiet 0
          default: bc_source = 1'b0;
        endcase
      end
    end
  endfunction

  reg [`RPC_PSEL_W-1:0] psel_r;
  // reset value is a full byte; only the index bits are stored
  wire [7:0] psel_rst;
  wire [31:0] psel_wide;
  reg [1:0] strap_s1_r;
  reg [1:0] strap_s2_r;
  reg strap_done_r;
  reg [7:0] gpio_s1_r;
  reg [7:0] gpio_s2_r;
  wire [8*NUM_PORTS-1:0] alias_bus;
  wire [8*NUM_PORTS-1:0] setup_bus;
  wire [8*NUM_PORTS-1:0] bcsel_bus;
  wire port_ok;
  wire wr_psel;
  wire wr_alias;
  wire wr_setup;
  wire wr_bcsel;
  reg [7:0] rdata_nxt;

  assign psel_rst = `RPC_RST_PORT_SEL;
  assign psel_wide = {{(32-`RPC_PSEL_W){1'b0}}, psel_r};
  assign port_ok = (psel_wide < NUM_PORTS);
  assign wr_psel = REG_WR && (REG_ADDR == `RPC_OFS_PORT_SEL);
  // per-port copy chosen by the port select
  assign wr_alias = REG_WR && port_ok && (REG_ADDR == `RPC_OFS_ALIAS7);
  assign wr_setup = REG_WR && port_ok && (REG_ADDR == `RPC_OFS_SETUP);
  assign wr_bcsel = REG_WR && port_ok && (REG_ADDR == `RPC_OFS_BC_SEL_LO);

  // pins cross in through two flops; chain runs during reset so strap is settled
  always @(posedge SYS_CLK) begin
    strap_s1_r <= STRAP_MODE;
    strap_s2_r <= strap_s1_r;
    gpio_s1_r <= LOCAL_GPIO;
    gpio_s2_r <= gpio_s1_r;
  end

  always @(posedge SYS_CLK) begin
    if (!NRST) begin
      psel_r <= psel_rst[`RPC_PSEL_W-1:0];
      strap_done_r <= 1'b0;
    end else begin
      strap_done_r <= 1'b1;
      if (wr_psel) begin
        psel_r <= REG_WDATA[`RPC_PSEL_W-1:0];
      end
    end
  end

  genvar i;
  generate
    for (i = 0; i < NUM_PORTS; i = i + 1) begin : g_port
      reg [7:0] alias_r;
      reg [4:0] setup_hi_r;
      reg [1:0] mode_r;
      reg [7:0] bcsel_r;
      reg gate_open_r;
      reg gate_open_nxt;
      reg pass_nxt;
      wire sel_me;
      wire csi;
      wire [6:0] remote_alias_addr_slot7;
      wire remote_auto_ack;
      wire wait_frame_start_count_one;
      wire wait_any_frame_start;
      wire pass_checksum_errored;
      wire pass_header_errored;
      wire drop_truncated_first_line;
      wire pass_length_errored;
      wire [1:0] link_input_mode;
      wire [3:0] backchannel_pin1_source;
      wire [3:0] backchannel_pin0_source;
      wire wait_en;
      wire fs_ok;
      wire open_now;
      wire err_ok;
      wire raw_ok;
      wire hit;
      wire bc0_nxt;
      wire bc1_nxt;

      assign sel_me = (psel_wide == i);
      assign csi = (link_input_mode == `RPC_MODE_CSI2);
      // named fields of the three per-port registers
      assign remote_alias_addr_slot7 = alias_r[`RPC_ALIAS_MSB:`RPC_ALIAS_LSB];
      assign remote_auto_ack = alias_r[`RPC_AUTO_ACK_BIT];
      assign wait_frame_start_count_one = setup_hi_r[`RPC_WAIT_FS1_BIT-3];
      assign wait_any_frame_start = setup_hi_r[`RPC_WAIT_FS_BIT-3];
      assign pass_checksum_errored = setup_hi_r[`RPC_FWD_CKSUM_BIT-3];
      assign pass_header_errored = setup_hi_r[`RPC_FWD_ECC_BIT-3];
      // bit 3 carries two meanings, picked by the input mode
      assign drop_truncated_first_line = setup_hi_r[`RPC_LINE_LEN_BIT-3];
      assign pass_length_errored = setup_hi_r[`RPC_LINE_LEN_BIT-3];
      assign link_input_mode = mode_r;
      assign backchannel_pin1_source = bcsel_r[`RPC_BC_PIN1_MSB:`RPC_BC_PIN1_LSB];
      assign backchannel_pin0_source = bcsel_r[`RPC_BC_PIN0_MSB:`RPC_BC_PIN0_LSB];
      // reserved bit 2 is no storage
      assign alias_bus[8*i+7:8*i] = alias_r;
      assign setup_bus[8*i+7:8*i] = {setup_hi_r, 1'b0, mode_r};
      assign bcsel_bus[8*i+7:8*i] = bcsel_r;
      assign INPUT_MODE[2*i+1:2*i] = link_input_mode;

      always @(posedge SYS_CLK) begin
        if (!NRST) begin
          alias_r <= `RPC_RST_ALIAS7;
          setup_hi_r <= `RPC_RST_SETUP_HI;
          mode_r <= `RPC_MODE_CSI2;
          bcsel_r <= `RPC_RST_BC_SEL_LO;
        end else begin
          if (wr_alias && sel_me) begin
            alias_r <= REG_WDATA;
          end
          if (wr_setup && sel_me) begin
            setup_hi_r <= REG_WDATA[7:3];
          end
          if (wr_setup && sel_me) begin
            mode_r <= REG_WDATA[`RPC_MODE_MSB:`RPC_MODE_LSB];
          end else if (!strap_done_r) begin
            mode_r <= strap_s2_r;
          end
          if (wr_bcsel && sel_me) begin
            bcsel_r <= REG_WDATA;
          end
        end
      end

      assign hit = TXN_VALID && (remote_alias_addr_slot7 != 7'h00) &&
                   (TXN_ADDR == remote_alias_addr_slot7);

      always @(posedge SYS_CLK) begin
        if (!NRST) begin
          ALIAS_HIT[i] <= 1'b0;
          ALIAS_ACK[i] <= 1'b0;
          REMAP_ADDR[7*i+6:7*i] <= 7'h00;
        end else begin
          ALIAS_HIT[i] <= hit;
          REMAP_ADDR[7*i+6:7*i] <= hit ? REMOTE_ID[7*i+6:7*i] : 7'h00;
          ALIAS_ACK[i] <= hit && TXN_WRITE && remote_auto_ack;
        end
      end

      assign wait_en = wait_frame_start_count_one || wait_any_frame_start;
      assign fs_ok = PKT_FS[i] && (!wait_frame_start_count_one || PKT_FCNT_ONE[i]);
      // the opening frame start passes itself
      assign open_now = !wait_en || gate_open_r || fs_ok;
      assign err_ok = (!PKT_CKSUM_ERR[i] || pass_checksum_errored) &&
                      (!PKT_ECC_ERR[i] || pass_header_errored) &&
                      (!PKT_LEN_ERR[i] || pass_length_errored);
      assign raw_ok = (!PKT_LINE_TRUNC[i] || !drop_truncated_first_line) &&
                      (!PKT_ECC_ERR[i] || pass_header_errored);

      // raw modes skip the wait gate and the checksum and length filters
      always @* begin
        gate_open_nxt = gate_open_r;
        pass_nxt = 1'b0;
        if (csi) begin
          if (PKT_VALID[i] && fs_ok) begin
            gate_open_nxt = 1'b1;
          end
          pass_nxt = PKT_VALID[i] && open_now && err_ok;
        end else begin
          pass_nxt = PKT_VALID[i] && raw_ok;
        end
      end

      // gate only opens once per reset; stream restarts need a reset
      always @(posedge SYS_CLK) begin
        if (!NRST) begin
          gate_open_r <= 1'b0;
          PKT_PASS[i] <= 1'b0;
        end else begin
          gate_open_r <= gate_open_nxt;
          PKT_PASS[i] <= pass_nxt;
        end
      end

      assign bc0_nxt = bc_source(backchannel_pin0_source, gpio_s2_r, FRAME_SYNC);
      assign bc1_nxt = bc_source(backchannel_pin1_source, gpio_s2_r, FRAME_SYNC);

      // registered so the back channel never sees decode glitches
      always @(posedge SYS_CLK) begin
        if (!NRST) begin
          BC_PIN0[i] <= 1'b0;
          BC_PIN1[i] <= 1'b0;
        end else begin
          BC_PIN0[i] <= bc0_nxt;
          BC_PIN1[i] <= bc1_nxt;
        end
      end
    end
  endgenerate

  always @* begin
    rdata_nxt = 8'h00;
    case (REG_ADDR)
      `RPC_OFS_PORT_SEL: rdata_nxt = {6'h00, psel_r};
      `RPC_OFS_ALIAS7: rdata_nxt = port_ok ? alias_bus[8*psel_r +: 8] : 8'h00;
      `RPC_OFS_SETUP: rdata_nxt = port_ok ? setup_bus[8*psel_r +: 8] : 8'h00;
      `RPC_OFS_BC_SEL_LO: rdata_nxt = port_ok ? bcsel_bus[8*psel_r +: 8] : 8'h00;
      default: rdata_nxt = 8'h00;
    endcase
  end

  always @(posedge SYS_CLK) begin
    if (!NRST) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      REG_RDATA <= rdata_nxt;
    end
  end

endmodule

// >>> test/rpc_host_model.sv
`timescale 1ns/1ps
module rpc_host_model (
  input wire SYS_CLK,
  input wire [7:0] REG_RDATA,
  output reg [7:0] REG_ADDR,
  output reg REG_WR,
  output reg REG_RD,
  output reg [7:0] REG_WDATA
);
  initial {REG_ADDR, REG_WR, REG_RD, REG_WDATA} = 18'h0_0000;
  task wr(input [7:0] a, input [7:0] d);
    @(posedge SYS_CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'h1;
    @(posedge SYS_CLK);
    REG_WR <= 1'h0;
    // stale data must not look valid
    REG_WDATA <= ~d;
  endtask
  task rd(input [7:0] a, output [7:0] d);
    @(posedge SYS_CLK);
    REG_ADDR <= a;
    REG_RD <= 1'h1;
    @(posedge SYS_CLK);
    REG_RD <= 1'h0;
    @(negedge SYS_CLK);
    d = REG_RDATA;
  endtask
endmodule

// >>> test/rx_port_config_regs_properties.sv
`timescale 1ns/1ps
module rpc_properties #(
  parameter NUM_PORTS = 4
) (
  input wire SYS_CLK,
  input wire NRST,
  input wire REG_WR,
  input wire REG_RD,
  input wire [7:0] REG_RDATA,
  input wire TXN_VALID,
  input wire TXN_WRITE,
  input wire [6:0] TXN_ADDR,
  input wire [7*NUM_PORTS-1:0] REMOTE_ID,
  input wire [NUM_PORTS-1:0] ALIAS_HIT,
  input wire [NUM_PORTS-1:0] ALIAS_ACK,
  input wire [7*NUM_PORTS-1:0] REMAP_ADDR,
  input wire [NUM_PORTS-1:0] PKT_VALID,
  input wire [NUM_PORTS-1:0] PKT_PASS,
  input wire [2*NUM_PORTS-1:0] INPUT_MODE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  property p_hit; ALIAS_HIT[0] |-> $past(TXN_VALID); endproperty
  a_hit: assert property (p_hit) else $error("hit without request");
  property p_remap; ALIAS_HIT[1] |-> REMAP_ADDR[13:7] == $past(REMOTE_ID[13:7]); endproperty
  a_remap: assert property (p_remap) else $error("wrong remap");
  property p_idle; !ALIAS_HIT[1] |-> REMAP_ADDR[13:7] == 7'h00; endproperty
  a_idle: assert property (p_idle) else $error("remap without hit");
  property p_zero; ALIAS_HIT[0] |-> $past(TXN_ADDR) != 7'h00; endproperty
  a_zero: assert property (p_zero) else $error("zero alias hit");
  property p_ack; ALIAS_ACK[1] |-> ALIAS_HIT[1]; endproperty
  a_ack: assert property (p_ack) else $error("ack without hit");
  property p_ackw; ALIAS_ACK[1] |-> $past(TXN_WRITE); endproperty
  a_ackw: assert property (p_ackw) else $error("ack on read");
  property p_pass; PKT_PASS[0] |-> $past(PKT_VALID[0]); endproperty
  a_pass: assert property (p_pass) else $error("pass without packet");
  property p_mode; $changed(INPUT_MODE) |-> $past(REG_WR) || !$past(NRST, 2); endproperty
  a_mode: assert property (p_mode) else $error("mode moved alone");
  property p_rd; $changed(REG_RDATA) |-> $past(REG_RD); endproperty
  a_rd: assert property (p_rd) else $error("read data moved alone");
endmodule

// >>> test/test_rx_port_config_regs.sv
`timescale 1ns/1ps
module test_rx_port_config_regs;
  reg clk = 1'h0;
  reg nrst = 1'h0;
  reg tv = 1'h0;
  reg tw = 1'h0;
  reg [6:0] ta = 7'h00;
  reg [27:0] pk = 28'h000_0000;
  reg fsync = 1'h0;
  reg [1:0] strap = 2'h2;
  reg [7:0] d;
  wire [7:0] addr, wdata, rdata, mode;
  wire wr, rd;
  wire [3:0] hit, ack, pass, bc0, bc1;
  wire [27:0] remap;
  wire [7:0] gpio = 8'ha5;
  integer n_fail = 0;
  integer n_checks = 0;
  integer cyc = 0;
  integer k;
  always #2.5 clk = ~clk;
  rpc_host_model i_host (.SYS_CLK(clk), .REG_RDATA(rdata), .REG_ADDR(addr), .REG_WR(wr),
    .REG_RD(rd), .REG_WDATA(wdata));
  rx_port_config_regs i_dut (.SYS_CLK(clk), .NRST(nrst), .REG_ADDR(addr), .REG_WR(wr),
    .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata), .STRAP_MODE(strap), .TXN_VALID(tv),
    .TXN_WRITE(tw), .TXN_ADDR(ta), .REMOTE_ID(28'h000_1980), .ALIAS_HIT(hit),
    .ALIAS_ACK(ack), .REMAP_ADDR(remap), .PKT_VALID(pk[3:0]), .PKT_FS(pk[7:4]),
    .PKT_FCNT_ONE(pk[11:8]), .PKT_CKSUM_ERR(pk[15:12]), .PKT_ECC_ERR(pk[19:16]),
    .PKT_LEN_ERR(pk[23:20]), .PKT_LINE_TRUNC(pk[27:24]), .PKT_PASS(pass),
    .INPUT_MODE(mode), .LOCAL_GPIO(gpio), .FRAME_SYNC(fsync), .BC_PIN0(bc0), .BC_PIN1(bc1));
  task chk(input [63:0] nm, input [31:0] s, input [31:0] x);
    n_checks = n_checks + 1;
    if (s !== x) begin
      $display("ERROR %0s exp %h seen %h", nm, x, s);
      n_fail = n_fail + 1;
    end
  endtask
  task rchk(input [7:0] a, input [7:0] x);
    i_host.rd(a, d);
    chk("rdata", d, x);
  endtask
  // expected back channel value for a select code and frame sync level
  function exp_bc(input [3:0] c, input f);
    exp_bc = c < 4'h8 ? gpio[c[2:0]] : c == 4'h9 ? 1'h1 : c == 4'ha ? f : 1'h0;
  endfunction
  task txn(input [6:0] a, input w, input [3:0] eh, input [3:0] ea);
    @(posedge clk);
    tv <= 1'h1;
    tw <= w;
    ta <= a;
    @(posedge clk);
    tv <= 1'h0;
    @(negedge clk);
    chk("hit", hit, eh);
    chk("ack", ack, ea);
  endtask
  // bits: valid fs fcnt1 cksum ecc len trunc
  task pkt(input [6:0] b, input x);
    @(posedge clk);
    for (k = 0; k < 7; k = k + 1) pk[4*k +: 4] <= {4{b[k]}};
    @(posedge clk);
    pk <= 28'h000_0000;
    @(negedge clk);
    chk("pass", pass[0], x);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail = n_fail + 1;
      end_of_test;
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'h1;
    repeat (2) @(posedge clk);
    rchk(8'h4c, 8'h00);
    rchk(8'h6c, 8'h00);
    rchk(8'h6d, 8'h7a);
    rchk(8'h6e, 8'h88);
    rchk(8'h70, 8'h00);
    chk("mode", mode, 8'haa);
    i_host.wr(8'h4c, 8'h01);
    i_host.wr(8'h6c, 8'h55);
    rchk(8'h6c, 8'h55);
    txn(7'h2a, 1'h1, 4'h2, 4'h2);
    chk("remap", remap, 28'h000_1980);
    txn(7'h2a, 1'h0, 4'h2, 4'h0);
    txn(7'h2b, 1'h1, 4'h0, 4'h0);
    txn(7'h00, 1'h1, 4'h0, 4'h0);
    i_host.wr(8'h6c, 8'h54);
    txn(7'h2a, 1'h1, 4'h2, 4'h0);
    i_host.wr(8'h4c, 8'h00);
    rchk(8'h6c, 8'h00);
    pkt(7'h01, 1'h1);
    pkt(7'h41, 1'h0);
    i_host.wr(8'h6d, 8'h70);
    @(negedge clk);
    chk("mode", mode, 8'ha8);
    pkt(7'h01, 1'h0);
    pkt(7'h03, 1'h1);
    pkt(7'h21, 1'h0);
    pkt(7'h11, 1'h1);
    i_host.wr(8'h6d, 8'h40);
    pkt(7'h11, 1'h0);
    pkt(7'h09, 1'h0);
    i_host.wr(8'h6d, 8'hff);
    rchk(8'h6d, 8'hfb);
    for (k = 0; k < 16; k = k + 1) begin
      i_host.wr(8'h6e, {~k[3:0], k[3:0]});
      fsync <= ~k[0];
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("bc0", bc0[0], exp_bc(k[3:0], ~k[0]));
      chk("bc1", bc1[0], exp_bc(~k[3:0], ~k[0]));
    end
    // second reset with the other strap; the wait gate must close again
    @(posedge clk);
    nrst <= 1'h0;
    strap <= 2'h0;
    repeat (8) @(posedge clk);
    nrst <= 1'h1;
    repeat (2) @(posedge clk);
    rchk(8'h6d, 8'h78);
    chk("mode", mode, 8'h00);
    i_host.wr(8'h6c, 8'h2b);
    txn(7'h15, 1'h1, 4'h1, 4'h1);
    i_host.wr(8'h6d, 8'hb8);
    pkt(7'h03, 1'h0);
    pkt(7'h07, 1'h1);
    pkt(7'h09, 1'h1);
    pkt(7'h21, 1'h1);
    i_host.wr(8'h6d, 8'h03);
    pkt(7'h09, 1'h1);
    pkt(7'h41, 1'h1);
    end_of_test;
  end
endmodule
bind rx_port_config_regs rpc_properties #(.NUM_PORTS(NUM_PORTS)) i_chk (.SYS_CLK(SYS_CLK),
  .NRST(NRST), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .TXN_VALID(TXN_VALID), .TXN_WRITE(TXN_WRITE), .TXN_ADDR(TXN_ADDR), .REMOTE_ID(REMOTE_ID),
  .ALIAS_HIT(ALIAS_HIT), .ALIAS_ACK(ALIAS_ACK), .REMAP_ADDR(REMAP_ADDR),
  .PKT_VALID(PKT_VALID), .PKT_PASS(PKT_PASS), .INPUT_MODE(INPUT_MODE));
